/* File: src/pcw_pkg.sv */
// Function
// - Postscaler codes divide by 1,2,4,8,16,32,64, 256
// - Bit 15 one bypasses USB PLL
// - USB input divider codes 1..6,10,12
// - Multiplier codes 15..21 and 24
package pcw_pkg;

    // ********************************************************************
    // Register map and field positions
    // ********************************************************************
    localparam logic [3:0] PCW_ADDR_CFG = 4'h0;
    localparam logic [3:0] PCW_ADDR_DEC = 4'h1;
    localparam logic [3:0] PCW_ADDR_FREQ = 4'h2;
    localparam logic [3:0] PCW_ADDR_CTRL = 4'h3;
    localparam logic [3:0] PCW_ADDR_REF = 4'h4;
    localparam int PCW_ODIV_LSB = 16;
    localparam int PCW_UBYP_BIT = 15;
    localparam int PCW_UIDIV_LSB = 8;
    localparam int PCW_MUL_LSB = 4;
    localparam int PCW_IDIV_LSB = 0;
    localparam logic [31:0] PCW_RSVD_MASK = 32'hFFF8_7888;
    localparam logic [31:0] PCW_CFG_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] PCW_REF_RESET = 32'h007A_1200;
    localparam int PCW_DIV_LAT = 3;

    // ********************************************************************
    // Decode tables
    // ********************************************************************
    localparam logic [63:0] PCW_DIV_TABLE = 64'h0C0A_0605_0403_0201;
    localparam logic [63:0] PCW_MUL_TABLE = 64'h1815_1413_1211_100F;

    typedef enum logic [1:0]
    {
        PCW_IDLE = 2'b00,
        PCW_MULT = 2'b01,
        PCW_DIVD = 2'b11
    } pcw_state_type;

endpackage

/* File: src/pcw_divider.sv */
`timescale 1ns/100ps
module pcw_divider
    import pcw_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Operands
    input wire logic start_in,
    input wire logic [31:0] dividend_in,
    input wire logic [7:0] divisor_in,
    // Result
    output logic [31:0] quotient_out,
    output logic done_out
);
    // Restoring divider, one quotient bit per cycle.
    logic [31:0] quo_q;
    logic [8:0] rem_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire logic [8:0] trial = {rem_q[7:0], quo_q[31]};
    wire logic ge = trial >= {1'b0, divisor_in};
    wire logic [8:0] diff = trial - {1'b0, divisor_in};

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            quo_q <= 32'h0000_0000;
            rem_q <= 9'h000;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start_in)
        begin
            quo_q <= dividend_in;
            rem_q <= 9'h000;
            cnt_q <= 6'h20;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end
        else if (busy_q)
        begin
            quo_q <= {quo_q[30:0], ge};
            rem_q <= ge ? diff : trial;
            cnt_q <= cnt_q - 6'h01;
            busy_q <= (cnt_q != 6'h01);
            done_q <= (cnt_q == 6'h01);
        end
        else
        begin
            done_q <= 1'b0;
        end
    end

    assign quotient_out = quo_q;
    assign done_out = done_q;
endmodule

/* File: src/pcw_top.sv */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
module pcw_top
    import pcw_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Decoded clock settings
    output logic [8:0] sys_pll_out_postscale_out,
    output logic usb_pll_bypass_sel_out,
    output logic usb_pll_enable_out,
    output logic [3:0] usb_pll_in_divider_out,
    output logic [4:0] sys_pll_multiplier_out,
    output logic [3:0] sys_pll_in_divider_out,
    output logic [31:0] sys_clk_hz_out,
    output logic freq_valid_out
);
    // ********************************************************************
    // Configuration word and field decode
    // ********************************************************************
    // The word is loaded once after reset by the configuration loader over
    // the register port; later writes re-evaluate it, which is harmless.
    logic [31:0] pll_default_config_word_q;
    logic [31:0] ref_hz_q;
    logic [31:0] rdata_q;
    logic [8:0] odiv_q;
    logic ubyp_q;
    // The enable has its own register so that the pin comes from a flip-flop.
    logic uen_q;
    logic [3:0] uidiv_q;
    logic [4:0] mul_q;
    logic [3:0] idiv_q;
    logic [31:0] freq_q;
    logic valid_q;
    logic recalc_q;
    logic [31:0] work_q;
    pcw_state_type state_q;

    wire logic [2:0] odiv_code = pll_default_config_word_q[PCW_ODIV_LSB +: 3];
    wire logic [2:0] uidiv_code = pll_default_config_word_q[PCW_UIDIV_LSB +: 3];
    wire logic [2:0] mul_code = pll_default_config_word_q[PCW_MUL_LSB +: 3];
    wire logic [2:0] idiv_code = pll_default_config_word_q[PCW_IDIV_LSB +: 3];
    wire logic [8:0] odiv_d = (odiv_code == 3'b111) ? 9'h100 : 9'(9'h001 << odiv_code);
    wire logic ubyp_d = pll_default_config_word_q[PCW_UBYP_BIT];
    wire logic [3:0] uidiv_d = PCW_DIV_TABLE[{uidiv_code, 3'b000} +: 4];
    wire logic [4:0] mul_d = PCW_MUL_TABLE[{mul_code, 3'b000} +: 5];
    wire logic [3:0] idiv_d = PCW_DIV_TABLE[{idiv_code, 3'b000} +: 4];
    // Reserved positions are left to the programmer; they are reported only.
    wire logic rsvd_ok = &(pll_default_config_word_q | ~PCW_RSVD_MASK);

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            odiv_q <= 9'h001;
            // Decoded outputs rest at the mildest settings until the first decode.
            ubyp_q <= 1'b1;
            uen_q <= 1'b0;
            uidiv_q <= 4'h1;
            mul_q <= 5'h0F;
            idiv_q <= 4'h1;
        end
        else
        begin
            odiv_q <= odiv_d;
            ubyp_q <= ubyp_d;
            uen_q <= !ubyp_d;
            uidiv_q <= uidiv_d;
            mul_q <= mul_d;
            idiv_q <= idiv_d;
        end
    end

    // ********************************************************************
    // Register port
    // ********************************************************************
    wire logic wr_cfg = wr_in && (addr_in == PCW_ADDR_CFG);
    wire logic wr_ref = wr_in && (addr_in == PCW_ADDR_REF);
    wire logic wr_ctrl = wr_in && (addr_in == PCW_ADDR_CTRL) && wdata_in[0];
    // Any of these writes makes the computed frequency stale.
    wire logic any_wr = wr_cfg || wr_ref || wr_ctrl;
    // The system input divider sits in bits 15 to 12 so that the status flags
    // in bits 10 to 8 keep their own positions.
    wire logic [31:0] dec_word = {odiv_q[8], 3'b000, uidiv_q, 3'b000, mul_q,
        idiv_q, 1'b0, rsvd_ok, ubyp_q, valid_q, odiv_q[7:0]};
    wire logic [31:0] rdata_d =
        (addr_in == PCW_ADDR_CFG) ? pll_default_config_word_q :
        (addr_in == PCW_ADDR_DEC) ? dec_word :
        (addr_in == PCW_ADDR_FREQ) ? freq_q :
        (addr_in == PCW_ADDR_CTRL) ? {31'h0000_0000, valid_q} :
        (addr_in == PCW_ADDR_REF) ? ref_hz_q : 32'h0000_0000;

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pll_default_config_word_q <= PCW_CFG_RESET;
            ref_hz_q <= PCW_REF_RESET;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            if (wr_cfg)
                pll_default_config_word_q <= wdata_in;
            if (wr_ref)
                ref_hz_q <= wdata_in;
            // Read data stand only in the cycle after each rd_in cycle and are zero otherwise, so a
            // late sample by the master shows a zero rather than stale data.
            rdata_q <= rd_in ? rdata_d : 32'h0000_0000;
        end
    end

    // ********************************************************************
    // Output frequency: divide by input divider, multiply, then postscale
    // ********************************************************************
    // Order matters: integer truncation after each step matches the chain.
    logic [31:0] quo;
    logic div_done;
    logic div_start_q;
    logic [7:0] divisor_q;
    wire logic [36:0] prod = quo * mul_q;

    // The divider is started by a one-cycle pulse and reports with a
    // one-cycle done pulse; its quotient then stands until the next start.

    pcw_divider u_div
    (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .start_in(div_start_q),
        .dividend_in(work_q),
        .divisor_in(divisor_q),
        .quotient_out(quo),
        .done_out(div_done)
    );

    // ********************************************************************
    // Calculation sequencer
    // ********************************************************************
    // One shared divider serves both divisions, so the chain takes about
    // seventy cycles; a slower result was traded for a single divider.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q <= PCW_IDLE;
            work_q <= 32'h0000_0000;
            freq_q <= 32'h0000_0000;
            valid_q <= 1'b0;
            recalc_q <= 1'b1;
            div_start_q <= 1'b0;
            divisor_q <= 8'h01;
        end
        else
        begin
            div_start_q <= 1'b0;
            if (any_wr)
            begin
                recalc_q <= 1'b1;
                valid_q <= 1'b0;
            end
            unique case (state_q)
                PCW_IDLE:
                begin
                    // A start waits out a write so that it uses the new settings.
                    if (recalc_q && !any_wr)
                    begin
                        recalc_q <= 1'b0;
                        work_q <= ref_hz_q;
                        divisor_q <= {4'h0, idiv_d};
                        div_start_q <= 1'b1;
                        state_q <= PCW_MULT;
                    end
                end
                PCW_MULT:
                begin
                    // The first quotient is multiplied; the product is postscaled.
                    if (div_done)
                    begin
                        work_q <= prod[31:0];
                        divisor_q <= odiv_q[8] ? 8'h00 : odiv_q[7:0];
                        div_start_q <= 1'b1;
                        state_q <= PCW_DIVD;
                    end
                end
                PCW_DIVD:
                begin
                    // Divide by 256 is a shift, so the divider result is ignored then.
                    // A write in the finishing cycle leaves the result marked stale.
                    if (div_done)
                    begin
                        freq_q <= odiv_q[8] ? {8'h00, work_q[31:8]} : quo;
                        valid_q <= !recalc_q && !any_wr;
                        state_q <= PCW_IDLE;
                    end
                end
            endcase
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Every output is a register, so consumers never see decode glitches.
    assign rdata_out = rdata_q;
    assign sys_pll_out_postscale_out = odiv_q;
    assign usb_pll_bypass_sel_out = ubyp_q;
    assign usb_pll_enable_out = uen_q;
    assign usb_pll_in_divider_out = uidiv_q;
    assign sys_pll_multiplier_out = mul_q;
    assign sys_pll_in_divider_out = idiv_q;
    assign sys_clk_hz_out = freq_q;
    assign freq_valid_out = valid_q;
endmodule

/* File: sim/pcw_top_assertions.sv */
`timescale 1ns/100ps
module pcw_top_assertions
    import pcw_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    // Decoded clock settings
    input wire logic [8:0] sys_pll_out_postscale_out,
    input wire logic usb_pll_bypass_sel_out,
    input wire logic usb_pll_enable_out,
    input wire logic [3:0] usb_pll_in_divider_out,
    input wire logic [4:0] sys_pll_multiplier_out,
    input wire logic [3:0] sys_pll_in_divider_out,
    input wire logic [31:0] sys_clk_hz_out,
    input wire logic freq_valid_out
);
    // ********************************************************************
    // Properties
    // ********************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire cfg_wr = wr_in && addr_in == PCW_ADDR_CFG;

    a_odiv_decode: assert property (cfg_wr |-> ##2 sys_pll_out_postscale_out ==
        (($past(wdata_in[18:16], 2) == 3'h7) ? 9'h100 : (9'h001 << $past(wdata_in[18:16], 2))))
        else $error("postscale decode wrong");
    a_usb_bypass: assert property (cfg_wr |-> ##2 usb_pll_bypass_sel_out == $past(wdata_in[15], 2))
        else $error("usb bypass wrong");
    a_usb_enable_inv: assert property (usb_pll_enable_out != usb_pll_bypass_sel_out)
        else $error("usb enable not inverse of bypass");
    a_uidiv_decode: assert property (cfg_wr |-> ##2 usb_pll_in_divider_out ==
        PCW_DIV_TABLE[8 * $past(wdata_in[10:8], 2) +: 4])
        else $error("usb divider decode wrong");
    a_mul_decode: assert property (cfg_wr |-> ##2 sys_pll_multiplier_out ==
        PCW_MUL_TABLE[8 * $past(wdata_in[6:4], 2) +: 5])
        else $error("multiplier decode wrong");
    a_idiv_decode: assert property (cfg_wr |-> ##2 sys_pll_in_divider_out ==
        PCW_DIV_TABLE[8 * $past(wdata_in[2:0], 2) +: 4])
        else $error("system divider decode wrong");
    a_valid_drop: assert property (cfg_wr |-> ##2 !freq_valid_out)
        else $error("valid not dropped after write");
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
        else $error("read data not zero outside read");
endmodule

bind pcw_top pcw_top_assertions u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .sys_pll_out_postscale_out(sys_pll_out_postscale_out),
    .usb_pll_bypass_sel_out(usb_pll_bypass_sel_out), .usb_pll_enable_out(usb_pll_enable_out),
    .usb_pll_in_divider_out(usb_pll_in_divider_out),
    .sys_pll_multiplier_out(sys_pll_multiplier_out),
    .sys_pll_in_divider_out(sys_pll_in_divider_out), .sys_clk_hz_out(sys_clk_hz_out),
    .freq_valid_out(freq_valid_out));

/* File: sim/pcw_top_tb.sv */
`timescale 1ns/100ps
module pcw_top_tb;
    import pcw_pkg::*;
    // ********************************************************************
    // Signals and design
    // ********************************************************************
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, hz;
    logic [8:0] odiv;
    logic byp, uen, valid;
    logic [3:0] uidiv, idiv;
    logic [4:0] mul;
    int fail_count = 0, n_checks = 0;
    int divt[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
    int mult[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
    int odt[8] = '{1, 2, 4, 8, 16, 32, 64, 256};

    pcw_top dut (.ref_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sys_pll_out_postscale_out(odiv),
        .usb_pll_bypass_sel_out(byp), .usb_pll_enable_out(uen),
        .usb_pll_in_divider_out(uidiv), .sys_pll_multiplier_out(mul),
        .sys_pll_in_divider_out(idiv), .sys_clk_hz_out(hz), .freq_valid_out(valid));

    initial forever #10 clk = ~clk;

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task stop_test();
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Each field gets a different code so that swapped fields show up.
    task t_decode();
        logic [31:0] w;
        int a, b, c, e, k;
        for (int i = 0; i < 8; i++)
        begin
            a = i;
            b = (i + 1) % 8;
            c = (i + 2) % 8;
            e = (i + 3) % 8;
            w = PCW_RSVD_MASK | (a << 16) | ((i % 2) << 15) | (b << 8) | (c << 4) | e;
            bus_wr(PCW_ADDR_CFG, w);
            @(posedge clk);
            #1;
            check("postscale", 32'(odiv), 32'(odt[a]));
            check("bypass", 32'(byp), 32'(i % 2));
            check("usb_enable", 32'(uen), 32'(1 - i % 2));
            check("usb_div", 32'(uidiv), 32'(divt[b]));
            check("mul", 32'(mul), 32'(mult[c]));
            check("sys_div", 32'(idiv), 32'(divt[e]));
            k = 0;
            while (valid !== 1'b1 && k < 500)
            begin
                @(posedge clk);
                #1 k++;
            end
            check("freq_valid", 32'(valid), 32'h0000_0001);
            check("freq", hz, 32'(PCW_REF_RESET / divt[e] * mult[c] / odt[a]));
        end
    endtask

    task t_regs();
        logic [31:0] d;
        bus_rd(PCW_ADDR_CFG, d);
        check("cfg_reset", d, PCW_CFG_RESET);
        bus_rd(PCW_ADDR_REF, d);
        check("ref_reset", d, PCW_REF_RESET);
        bus_wr(4'hF, 32'h1234_5678);
        bus_rd(4'hF, d);
        check("unmapped", d, 32'h0000_0000);
    endtask

    task wait_valid();
        int k;
        k = 0;
        while (valid !== 1'b1 && k < 500)
        begin
            @(posedge clk);
            #1 k++;
        end
    endtask

    // Reference and recompute paths, on the last word that t_decode left.
    task t_ref();
        logic [31:0] d, f;
        f = 32'h00F4_2400 / 32'(divt[2]) * 32'(mult[1]) / 32'(odt[7]);
        bus_wr(PCW_ADDR_REF, 32'h00F4_2400);
        #1 check("valid_drop_ref", 32'(valid), 32'h0000_0000);
        wait_valid();
        check("freq_ref", hz, f);
        bus_rd(PCW_ADDR_FREQ, d);
        check("freq_reg", d, f);
        bus_rd(PCW_ADDR_CTRL, d);
        check("ctrl_reg", d, 32'h0000_0001);
        bus_rd(PCW_ADDR_DEC, d);
        check("dec_reg", d, 32'h8110_3700);
        bus_wr(PCW_ADDR_CTRL, 32'h0000_0001);
        #1 check("valid_drop_ctrl", 32'(valid), 32'h0000_0000);
        wait_valid();
        check("freq_recalc", hz, f);
    endtask

    // ********************************************************************
    // Main sequence and watchdog
    // ********************************************************************
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_decode();
        t_ref();
        stop_test();
    end

    initial
    begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
